// [rtl/rsfc_top.sv]
// Reset state and flag controller with APB register access
`timescale 1ns/100ps
`default_nettype none
module rsfc_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Reset sources
  input wire logic i_external_reset_pin_n,
  input wire logic i_low_voltage_reset,
  input wire logic i_watchdog_timer_overflow,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [rsfc_pkg::RSFC_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Core state outputs
  output logic [7:0] o_program_counter_low_byte,
  output logic [2:0] o_stack_pointer,
  output logic o_watchdog_timeout_flag,
  output logic o_power_down_flag,
  output logic o_halted,
  output logic [4:0] o_reset_cause,
  output logic o_timers_on,
  output logic [7:0] o_prescaler
);
  import rsfc_pkg::*;

  // Run state
  rsfc_state_t state_r;
  // Reset-cause flags and counters
  logic tmo_flag_r;
  logic pd_flag_r;
  logic [7:0] pc_low_r;
  logic [2:0] sp_r;
  logic [7:0] wdt_r;
  logic [7:0] presc_r;
  logic [7:0] int_en_r;
  logic timers_on_r;
  logic [4:0] cause_r;
  // Event decode
  logic pin_evt;
  logic wdt_evt;
  logic full_load;
  // APB decode
  logic acc;
  logic wr;
  logic rd_pend_r;
  logic mem_hit;
  // Decoded store select, bit 3 marks a hit
  logic [3:0] shadow_sel;
  // Pin or supply reset seen in the previous cycle
  logic pin_evt_d_r;
  logic [2:0] mem_idx;
  logic [7:0] mem_rd;
  logic [63:0] defaults;

  // Map an address to a shadow index
  function automatic logic [3:0] shadow_idx(input logic [7:0] a);
    case (a)
      RSFC_A_WD_SET: shadow_idx = 4'h8;
      RSFC_A_TIM0_CTRL: shadow_idx = 4'h9;
      RSFC_A_TIM1_CTRL: shadow_idx = 4'ha;
      RSFC_A_CMP_CTRL: shadow_idx = 4'hb;
      RSFC_A_PORT: shadow_idx = 4'hc;
      RSFC_A_DIR: shadow_idx = 4'hd;
      default: shadow_idx = 4'h0;
    endcase
  endfunction

  // Reset events, pin and supply monitor act alike
  assign pin_evt = !i_external_reset_pin_n || i_low_voltage_reset;
  assign wdt_evt = i_watchdog_timer_overflow && !pin_evt;
  // Every kind except halted watchdog loads defaults
  assign full_load = i_sys_rst || pin_evt || (wdt_evt && state_r != RSFC_ST_HALT);
  // Bus strobes
  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite;
  assign shadow_sel = shadow_idx(i_paddr[7:0]);
  assign mem_hit = shadow_sel[3];
  assign mem_idx = shadow_sel[2:0];
  // Store defaults: watchdog setting, timer controls, comparator, port, direction
  assign defaults = {16'h0000, RSFC_PORT_RST, RSFC_PORT_RST, RSFC_CMP_CTRL_RST,
                     RSFC_TMRC_RST, RSFC_TMRC_RST, RSFC_WD_SET_RST};

  // Peripheral register store
  rsfc_shadow rsfc_shadow_i (
    .i_core_clk(i_core_clk),
    .i_we(wr && mem_hit && !full_load),
    .i_waddr(mem_idx),
    .i_wdata(i_pwdata[7:0]),
    .i_load(full_load),
    .i_defaults(defaults),
    .i_raddr(mem_idx),
    .o_rdata(mem_rd)
  );

  // Run state machine
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_r <= RSFC_ST_POR;
    end else if (pin_evt || wdt_evt) begin
      // Any reset wakes the core
      state_r <= RSFC_ST_RUN;
    end else begin
      case (state_r)
        RSFC_ST_POR: state_r <= RSFC_ST_RUN;
        RSFC_ST_RUN: begin
          // Halt command enters power-down
          if (wr && i_paddr == RSFC_A_CTRL && i_pwdata[RSFC_B_HALT_CMD]) begin
            state_r <= RSFC_ST_HALT;
          end
        end
        RSFC_ST_HALT: state_r <= RSFC_ST_HALT;
        default: state_r <= RSFC_ST_POR;
      endcase
    end
  end

  // Watchdog timeout and power-down flags
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tmo_flag_r <= 1'b0;
      pd_flag_r <= 1'b0;
    end else if (pin_evt) begin
      if (state_r == RSFC_ST_HALT) begin
        tmo_flag_r <= 1'b0;
        pd_flag_r <= 1'b1;
      end
      // Running pin or low-voltage reset keeps both
    end else if (wdt_evt) begin
      tmo_flag_r <= 1'b1;
      if (state_r == RSFC_ST_HALT) begin
        pd_flag_r <= 1'b1;
      end
    end else if (wr && i_paddr == RSFC_A_CTRL && state_r == RSFC_ST_RUN) begin
      if (i_pwdata[RSFC_B_HALT_CMD]) begin
        pd_flag_r <= 1'b1;
        tmo_flag_r <= 1'b0;
      end else if (i_pwdata[RSFC_B_CLRWDT_CMD]) begin
        pd_flag_r <= 1'b0;
        tmo_flag_r <= 1'b0;
      end
    end
  end

  // Program counter and stack pointer
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || pin_evt || wdt_evt) begin
      pc_low_r <= RSFC_PC_LOW_RST;
      sp_r <= RSFC_SP_TOP;
    end else if (state_r == RSFC_ST_RUN) begin
      // Stand-in for fetch: counter advances while running
      pc_low_r <= pc_low_r + 8'h01;
    end
  end

  // Watchdog counter
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || pin_evt || wdt_evt) begin
      wdt_r <= RSFC_WDT_RST;
    end else if (wr && i_paddr == RSFC_A_CTRL && i_pwdata[RSFC_B_CLRWDT_CMD]) begin
      wdt_r <= RSFC_WDT_RST;
    end else begin
      wdt_r <= wdt_r + RSFC_WDT_ONE;
    end
  end

  // Interrupt enables, timers and prescaler
  always_ff @(posedge i_core_clk) begin
    if (full_load) begin
      int_en_r <= RSFC_INT_RST;
      timers_on_r <= 1'b0;
      presc_r <= RSFC_PRESC_RST;
    end else begin
      if (wr && i_paddr == RSFC_A_INT) begin
        int_en_r <= i_pwdata[7:0];
        timers_on_r <= i_pwdata[8];
      end
      if (timers_on_r && state_r == RSFC_ST_RUN) begin
        presc_r <= presc_r + 8'h01;
      end
    end
  end

  // Delayed pin event, so a held pin is classified only once
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pin_evt_d_r <= 1'b0;
    end else begin
      pin_evt_d_r <= pin_evt;
    end
  end

  // Last reset cause, taken on the first cycle of a pin reset
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cause_r <= RSFC_CAUSE_POR;
    end else if (pin_evt && !pin_evt_d_r) begin
      // Later cycles of a held pin would see the core running again
      cause_r <= (state_r == RSFC_ST_HALT) ? RSFC_CAUSE_PIN_HALT : RSFC_CAUSE_PIN_RUN;
    end else if (wdt_evt) begin
      cause_r <= (state_r == RSFC_ST_HALT) ? RSFC_CAUSE_WDT_HALT : RSFC_CAUSE_WDT_RUN;
    end
  end

  // APB: two-cycle access for reads of the store, one otherwise
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rd_pend_r <= 1'b0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      rd_pend_r <= 1'b0;
      if (acc && !o_pready && !rd_pend_r) begin
        // First cycle of access
        if (!i_pwrite && mem_hit) begin
          rd_pend_r <= 1'b1;
        end else begin
          o_pready <= 1'b1;
          o_pslverr <= !(mem_hit || i_paddr == RSFC_A_CTRL || i_paddr == RSFC_A_STAT ||
                         i_paddr == RSFC_A_INT || i_paddr == RSFC_A_WDT);
          case (i_paddr)
            RSFC_A_STAT: o_prdata <= {27'h0, cause_r} << 8 |
                                     {29'h0, state_r == RSFC_ST_HALT, pd_flag_r, tmo_flag_r};
            RSFC_A_INT: o_prdata <= {23'h0, timers_on_r, int_en_r};
            RSFC_A_WDT: o_prdata <= {24'h0, wdt_r};
            default: o_prdata <= 32'h0000_0000;
          endcase
        end
      end else if (rd_pend_r) begin
        // Store data ready
        o_pready <= 1'b1;
        o_prdata <= {24'h0, mem_rd};
      end
    end
  end

  // Output registers
  always_ff @(posedge i_core_clk) begin
    o_program_counter_low_byte <= pc_low_r;
    o_stack_pointer <= sp_r;
    o_watchdog_timeout_flag <= tmo_flag_r;
    o_power_down_flag <= pd_flag_r;
    o_halted <= state_r == RSFC_ST_HALT;
    o_reset_cause <= cause_r;
    o_timers_on <= timers_on_r;
    o_prescaler <= presc_r;
  end
endmodule
`default_nettype wire

// [include/rsfc_pkg.sv]
// Constants, state and cause codes for the reset state and flag controller
// How it works
// - Halted watchdog wake clears counter, stack, sets flag
// - Two reset-cause flags live in status register
// - Power-on reset clears both flags
// - Running pin or low-voltage reset keeps flags
// - Running watchdog reset sets timeout, keeps power-down
// - Halted watchdog reset sets both flags
// - Power-on zeroes counter, stack at top
// - Power-on disables every interrupt source
// - Any reset clears watchdog, counting restarts
// - Power-on switches timer counters off
// - Power-on clears timer prescaler
// - Power-on makes all port pins inputs
// - Full resets load documented register defaults
// - Halted watchdog keeps peripherals, clears counter low
// - Halt sets power-down; clear-watchdog, power-up clear it
package rsfc_pkg;
  // Run state of the core
  typedef enum logic [2:0] {
    RSFC_ST_POR = 3'h1,
    RSFC_ST_RUN = 3'h2,
    RSFC_ST_HALT = 3'h4
  } rsfc_state_t;
  // Last reset cause, one-hot
  localparam logic [4:0] RSFC_CAUSE_POR = 5'h01;
  localparam logic [4:0] RSFC_CAUSE_PIN_RUN = 5'h02;
  localparam logic [4:0] RSFC_CAUSE_PIN_HALT = 5'h04;
  localparam logic [4:0] RSFC_CAUSE_WDT_RUN = 5'h08;
  localparam logic [4:0] RSFC_CAUSE_WDT_HALT = 5'h10;
  // Register defaults
  localparam logic [7:0] RSFC_PC_LOW_RST = 8'h00;
  localparam logic [7:0] RSFC_WD_SET_RST = 8'h07;
  localparam logic [7:0] RSFC_TMRC_RST = 8'h08;
  localparam logic [7:0] RSFC_CMP_CTRL_RST = 8'hb0;
  localparam logic [7:0] RSFC_PORT_RST = 8'hff;
  localparam logic [7:0] RSFC_INT_RST = 8'h00;
  localparam logic [7:0] RSFC_PRESC_RST = 8'h00;
  localparam logic [2:0] RSFC_SP_TOP = 3'h0;
  localparam logic [7:0] RSFC_WDT_RST = 8'h00;
  localparam logic [7:0] RSFC_WDT_ONE = 8'h01;
  // Bus layout
  localparam int RSFC_AW = 8;
  localparam logic [7:0] RSFC_A_CTRL = 8'h00;
  localparam logic [7:0] RSFC_A_STAT = 8'h04;
  localparam logic [7:0] RSFC_A_WD_SET = 8'h08;
  localparam logic [7:0] RSFC_A_TIM0_CTRL = 8'h0c;
  localparam logic [7:0] RSFC_A_TIM1_CTRL = 8'h10;
  localparam logic [7:0] RSFC_A_CMP_CTRL = 8'h14;
  localparam logic [7:0] RSFC_A_PORT = 8'h18;
  localparam logic [7:0] RSFC_A_DIR = 8'h1c;
  localparam logic [7:0] RSFC_A_INT = 8'h20;
  localparam logic [7:0] RSFC_A_WDT = 8'h24;
  // Fields of the status word
  localparam int RSFC_B_TIMEOUT = 0;
  localparam int RSFC_B_PWR_DOWN = 1;
  localparam int RSFC_B_HALTED = 2;
  // Fields of the control word
  localparam int RSFC_B_HALT_CMD = 0;
  localparam int RSFC_B_CLRWDT_CMD = 1;
endpackage

// [rtl/rsfc_shadow.sv]
// Small register store for the reset-affected peripheral registers
`timescale 1ns/100ps
`default_nettype none
module rsfc_shadow (
  // Clock
  input wire logic i_core_clk,
  // Write port
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Bulk default load
  input wire logic i_load,
  input wire logic [63:0] i_defaults,
  // Read port
  input wire logic [2:0] i_raddr,
  output logic [7:0] o_rdata
);
  // Eight byte words
  logic [7:0] mem_r [8];

  // Load defaults or accept a write
  always_ff @(posedge i_core_clk) begin
    if (i_load) begin
      for (int k = 0; k < 8; k++) begin
        mem_r[k] <= i_defaults[k*8 +: 8];
      end
    end else if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // Registered read
  always_ff @(posedge i_core_clk) begin
    o_rdata <= mem_r[i_raddr];
  end
endmodule
`default_nettype wire

// [test/rsfc_checker.sv]
// Port assertions for the reset state and flag controller
`timescale 1ns/100ps
`default_nettype none
module rsfc_checker (
  // Clock, reset and reset sources
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_external_reset_pin_n,
  input wire logic i_low_voltage_reset,
  input wire logic i_watchdog_timer_overflow,
  // Bus handshake
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Core state
  input wire logic [7:0] o_program_counter_low_byte,
  input wire logic [2:0] o_stack_pointer,
  input wire logic o_watchdog_timeout_flag,
  input wire logic o_power_down_flag,
  input wire logic o_halted,
  input wire logic [4:0] o_reset_cause,
  input wire logic o_timers_on,
  input wire logic [7:0] o_prescaler
);
  import rsfc_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // No pin or supply reset present
  logic quiet;
  assign quiet = i_external_reset_pin_n && !i_low_voltage_reset;
  por_flags_a: assert property ($fell(i_sys_rst) |-> !o_watchdog_timeout_flag
    && !o_power_down_flag && o_reset_cause == RSFC_CAUSE_POR) else $error("power-on flags");
  por_core_a: assert property ($fell(i_sys_rst) |-> o_stack_pointer == RSFC_SP_TOP
    && !o_timers_on && o_prescaler == RSFC_PRESC_RST) else $error("power-on core state");
  pin_zero_a: assert property (!quiet |-> ##[1:3] o_stack_pointer == RSFC_SP_TOP
    && o_program_counter_low_byte == RSFC_PC_LOW_RST) else $error("pin reset counter");
  wdt_run_a: assert property (i_watchdog_timer_overflow && quiet && !o_halted
    |-> ##[1:3] o_watchdog_timeout_flag) else $error("running watchdog flag");
  wdt_halt_a: assert property (i_watchdog_timer_overflow && quiet && o_halted
    |-> ##[1:3] o_watchdog_timeout_flag && o_power_down_flag && o_stack_pointer == 3'h0)
    else $error("halted watchdog flags");
  pin_keep_a: assert property (!quiet [*4] |-> $stable(o_watchdog_timeout_flag)
    && $stable(o_power_down_flag)) else $error("running pin reset changed flags");
  pin_halt_a: assert property (!i_external_reset_pin_n && o_halted
    |-> ##[1:3] !o_watchdog_timeout_flag && o_power_down_flag) else $error("halted pin flags");
  bus_answer_a: assert property (i_psel && i_penable && !o_pready |-> ##[1:3] o_pready)
    else $error("bus answer late");
  bus_err_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
endmodule
`default_nettype wire

// [test/rsfc_src_model.sv]
// Model of the reset pin, supply monitor and watchdog feeding the controller
`timescale 1ns/100ps
`default_nettype none
module rsfc_src_model (
  // Clock
  input wire logic i_core_clk,
  // Reset sources toward the controller
  output logic o_external_reset_pin_n,
  output logic o_low_voltage_reset,
  output logic o_watchdog_timer_overflow
);
  // Pin pulled up, monitor and watchdog quiet at start
  initial begin
    o_external_reset_pin_n = 1'b1;
    o_low_voltage_reset = 1'b0;
    o_watchdog_timer_overflow = 1'b0;
  end
  // Pin (supply low) or supply monitor (supply high) active for n cycles
  task automatic hold_reset(input logic supply, input int n);
    @(posedge i_core_clk);
    o_low_voltage_reset <= supply;
    o_external_reset_pin_n <= supply;
    repeat (n) @(posedge i_core_clk);
    o_low_voltage_reset <= 1'b0;
    o_external_reset_pin_n <= 1'b1;
  endtask
  // One-cycle time-out pulse
  task automatic wdt_pulse();
    @(posedge i_core_clk);
    o_watchdog_timer_overflow <= 1'b1;
    @(posedge i_core_clk);
    o_watchdog_timer_overflow <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/tb_reset_state_and_flag_control.sv]
// Testbench for the reset state and flag controller
`timescale 1ns/100ps
`default_nettype none
module tb_reset_state_and_flag_control;
  import rsfc_pkg::*;
  // Design-facing signals, named as the ports
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [RSFC_AW-1:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata;
  logic o_pready, o_pslverr, o_watchdog_timeout_flag, o_power_down_flag, o_halted;
  logic i_external_reset_pin_n, i_low_voltage_reset, i_watchdog_timer_overflow;
  logic [7:0] o_program_counter_low_byte, o_prescaler;
  logic [2:0] o_stack_pointer;
  logic [4:0] o_reset_cause;
  logic o_timers_on, err;
  logic [31:0] rd, wd0;
  int num_errors = 0, check_count = 0;
  // Store addresses and their defaults
  logic [7:0] st_a [6] = '{RSFC_A_WD_SET, RSFC_A_TIM0_CTRL, RSFC_A_TIM1_CTRL,
    RSFC_A_CMP_CTRL, RSFC_A_PORT, RSFC_A_DIR};
  logic [7:0] st_d [6] = '{RSFC_WD_SET_RST, RSFC_TMRC_RST, RSFC_TMRC_RST,
    RSFC_CMP_CTRL_RST, RSFC_PORT_RST, RSFC_PORT_RST};
  always #5 i_core_clk = ~i_core_clk;
  rsfc_top rsfc_top_i (.i_core_clk, .i_sys_rst, .i_external_reset_pin_n,
    .i_low_voltage_reset, .i_watchdog_timer_overflow, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_program_counter_low_byte,
    .o_stack_pointer, .o_watchdog_timeout_flag, .o_power_down_flag, .o_halted,
    .o_reset_cause, .o_timers_on, .o_prescaler);
  rsfc_src_model rsfc_src_model_i (.i_core_clk, .o_external_reset_pin_n(i_external_reset_pin_n),
    .o_low_voltage_reset(i_low_voltage_reset),
    .o_watchdog_timer_overflow(i_watchdog_timer_overflow));
  // Comparison with count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Counts, verdict and stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One APB transfer, bounded wait for ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge i_core_clk);
      if (o_pready === 1'b1) break;
    end
    if (n == 20) begin
      num_errors++;
      end_sim();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // Read and compare under a mask
  task automatic rdchk(input string w, input logic [7:0] a, input logic [31:0] e, m);
    apb(1'b0, a, 32'h0);
    check(w, rd & m, e);
  endtask
  // Store contents: scribbled value kept, or defaults
  task automatic chk_store(input logic kept);
    for (int i = 0; i < 6; i++) rdchk("store", st_a[i], kept ? 32'h5a : st_d[i], 32'hff);
  endtask
  task automatic scribble();
    for (int i = 0; i < 6; i++) apb(1'b1, st_a[i], 32'h5a);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rdchk("status", RSFC_A_STAT, 32'h100, 32'h1f07);
    chk_store(1'b0);
    rdchk("int", RSFC_A_INT, 32'h0, 32'h1ff);
    check("prescaler", {o_timers_on, o_prescaler}, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    check("unmapped err", err, 32'h1);
    $display("test power-on done");
    scribble();
    rsfc_src_model_i.wdt_pulse();
    rdchk("status", RSFC_A_STAT, 32'h801, 32'h1f03);
    chk_store(1'b0);
    scribble();
    rsfc_src_model_i.hold_reset(1'b0, 5);
    rdchk("status", RSFC_A_STAT, 32'h201, 32'h1f03);
    chk_store(1'b0);
    rsfc_src_model_i.hold_reset(1'b1, 5);
    rdchk("wdt cleared", RSFC_A_WDT, 32'h0, 32'hf0);
    wd0 = rd;
    apb(1'b0, RSFC_A_WDT, 32'h0);
    check("wdt counting", {31'h0, rd > wd0}, 32'h1);
    rdchk("status", RSFC_A_STAT, 32'h201, 32'h1f03);
    $display("test running resets done");
    scribble();
    apb(1'b1, RSFC_A_CTRL, 32'h1);
    rdchk("status", RSFC_A_STAT, 32'h206, 32'h1f07);
    rsfc_src_model_i.wdt_pulse();
    rdchk("status", RSFC_A_STAT, 32'h1003, 32'h1f03);
    chk_store(1'b1);
    apb(1'b1, RSFC_A_CTRL, 32'h1);
    rsfc_src_model_i.hold_reset(1'b0, 5);
    rdchk("status", RSFC_A_STAT, 32'h402, 32'h1f03);
    chk_store(1'b0);
    apb(1'b1, RSFC_A_CTRL, 32'h2);
    rdchk("status", RSFC_A_STAT, 32'h400, 32'h1f03);
    $display("test halted resets done");
    apb(1'b1, RSFC_A_INT, 32'h1ff);
    repeat (2) @(posedge i_core_clk);
    check("timers on", o_timers_on, 32'h1);
    check("prescaler counting", {31'h0, o_prescaler != 8'h00}, 32'h1);
    @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rdchk("status", RSFC_A_STAT, 32'h100, 32'h1f07);
    rdchk("int", RSFC_A_INT, 32'h0, 32'h1ff);
    check("prescaler", {o_timers_on, o_prescaler}, 32'h0);
    $display("test mid-run power-on reset done");
    end_sim();
  end
endmodule
bind rsfc_top rsfc_checker rsfc_checker_i (.i_core_clk, .i_sys_rst, .i_external_reset_pin_n,
  .i_low_voltage_reset, .i_watchdog_timer_overflow, .i_psel, .i_penable, .o_pready,
  .o_pslverr, .o_program_counter_low_byte, .o_stack_pointer, .o_watchdog_timeout_flag,
  .o_power_down_flag, .o_halted, .o_reset_cause, .o_timers_on, .o_prescaler);
`default_nettype wire
